// file: src/dpsc_core.sv
// dpsc_core: command decoder, wipers, stored slots, sleep and ready handling
`timescale 1ns/1ps
`default_nettype none
module dpsc_core
	import dpsc_pkg::*;
#(
	parameter int NUM_CH      = DEF_CH,
	parameter int BUSY_CYCLES = SAVE_CYCLES
) (
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_in,
	input  wire logic                  spi_clk_in,
	input  wire logic                  spi_cs_n_in,
	input  wire logic                  spi_sdi_in,
	input  wire logic                  wp_n_in,
	output logic                       spi_sdo_out,
	output logic                       ready_out,
	output logic                       asleep_out,
	output logic [NUM_CH-1:0][7:0]     wiper_out,
	output logic [NUM_CH-1:0]          buffer_on_out
);
	localparam int CH_W = (NUM_CH > 2) ? 2 : 1;
	localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(BUSY_CYCLES);
	localparam logic [BUSY_W-1:0] BUSY_ONE  = 16'h0001;

	typedef struct packed {
		logic [NUM_CH-1:0][7:0]                      wiper;
		logic [NUM_CH-1:0]                           bufm;
		logic [NUM_CH-1:0][NUM_SLOTS-1:0][DATA_MSB:0] slot;
		logic                                        asleep;
		dpsc_word_type                               rd_word;
		logic [BUSY_W-1:0]                           busy_cnt;
		logic                                        ready;
		logic                                        tog_seen;
	} dpsc_state_type;

	// power-up image: every slot 0 content already loaded into its wiper
	localparam dpsc_state_type ST_RESET = '{
		wiper:    {NUM_CH{SLOT_POWERUP[WIPER_MSB:0]}},
		bufm:     {NUM_CH{SLOT_POWERUP[DATA_MSB]}},
		slot:     {(NUM_CH * NUM_SLOTS){SLOT_POWERUP}},
		asleep:   1'b1,
		rd_word:  '0,
		busy_cnt: '0,
		ready:    1'b1,
		tog_seen: 1'b0
	};

	initial begin
		if (NUM_CH < 2 || NUM_CH > 4) $error("dpsc_core channel count must be 2 to 4");
		if (BUSY_CYCLES < 1 || BUSY_CYCLES >= (1 << BUSY_W)) $error("dpsc_core busy count out of range");
	end

	dpsc_frame_if fif ();

	dpsc_state_type  st;
	dpsc_state_type  next_st;
	logic            tog_s;
	logic            wp_n_s;
	logic            cmd_valid;
	dpsc_op_type     cmd_op;
	logic [1:0]      cmd_slot;
	logic [1:0]      cmd_ch;
	logic [CH_W-1:0] ch;
	logic            ch_ok;
	dpsc_word_type   cmd_data;
	logic            wp_ok;
	logic            busy_op;

	dpsc_link u_link (
		.spi_clk_in  (spi_clk_in),
		.rst_in      (rst_in),
		.spi_cs_n_in (spi_cs_n_in),
		.spi_sdi_in  (spi_sdi_in),
		.spi_sdo_out (spi_sdo_out),
		.fif         (fif.link)
	);

	// frame event crosses as a toggle; the frame word is settled by then
	dpsc_sync #(.W(1)) u_sync_tog (
		.clk_in (clk_sys_in),
		.rst_in (rst_in),
		.d_in   (fif.frame_tog),
		.q_out  (tog_s)
	);

	dpsc_sync #(.W(1)) u_sync_wp (
		.clk_in (clk_sys_in),
		.rst_in (rst_in),
		.d_in   (wp_n_in),
		.q_out  (wp_n_s)
	);

	// field decode of the held frame
	always_comb begin
		cmd_valid = (tog_s != st.tog_seen);
		cmd_op    = dpsc_op_type'(fif.frame[OP_MSB:OP_LSB]);
		cmd_slot  = fif.frame[SLOT_MSB:SLOT_LSB];
		cmd_ch    = fif.frame[CH_MSB:CH_LSB];
		ch        = cmd_ch[CH_W-1:0];
		ch_ok     = ({30'h0, cmd_ch} < NUM_CH);
		cmd_data  = fif.frame[DATA_MSB:0];
		wp_ok     = wp_n_s;
		busy_op   = (cmd_op == OP_READ_TAP) || (cmd_op == OP_READ_SLOT) ||
		            (cmd_op == OP_PROG_SLOT) || (cmd_op == OP_RECALL) ||
		            (cmd_op == OP_STORE) || (cmd_op == OP_ERASE);
	end

	// command execution; one frame per toggle, ready counts down the slot access
	always_comb begin
		next_st = st;
		next_st.tog_seen = tog_s;
		if (st.busy_cnt != '0) begin
			next_st.busy_cnt = st.busy_cnt - BUSY_ONE;
		end
		if (cmd_valid && st.asleep) begin
			if (cmd_op == OP_WAKE) begin
				next_st.asleep = 1'b0;
			end
		end else if (cmd_valid) begin
			if (busy_op) begin
				next_st.busy_cnt = BUSY_LOAD;
			end
			unique case (cmd_op)
				OP_NOP: begin
					next_st.busy_cnt = next_st.busy_cnt;
				end
				OP_WAKE: begin
					next_st.asleep = 1'b0;
				end
				OP_READ_TAP: begin
					if (ch_ok) next_st.rd_word = {st.bufm[ch], st.wiper[ch]};
				end
				OP_WRITE: begin
					if (ch_ok) next_st.wiper[ch] = cmd_data[WIPER_MSB:0];
				end
				OP_READ_SLOT: begin
					if (ch_ok) next_st.rd_word = st.slot[ch][cmd_slot];
				end
				OP_PROG_SLOT: begin
					// nine data bits, buffer bit included; no erase check, the host owns that
					if (ch_ok && wp_ok) next_st.slot[ch][cmd_slot] = cmd_data;
				end
				OP_RECALL: begin
					if (ch_ok) begin
						next_st.wiper[ch] = st.slot[ch][cmd_slot][WIPER_MSB:0];
						next_st.bufm[ch]  = st.slot[ch][cmd_slot][DATA_MSB];
					end
				end
				OP_STORE: begin
					if (ch_ok && wp_ok) begin
						next_st.slot[ch][cmd_slot] = {st.bufm[ch], st.wiper[ch]};
					end
				end
				OP_STEP_UP: begin
					if (ch_ok && st.wiper[ch] != WIPER_MAX) begin
						next_st.wiper[ch] = st.wiper[ch] + STEP;
					end
				end
				OP_STEP_DN: begin
					if (ch_ok && st.wiper[ch] != WIPER_MIN) begin
						next_st.wiper[ch] = st.wiper[ch] - STEP;
					end
				end
				OP_SLEEP: begin
					next_st.asleep = 1'b1;
				end
				OP_ERASE: begin
					if (ch_ok && wp_ok) next_st.slot[ch][cmd_slot] = SLOT_ERASED;
				end
				OP_SW_RESET: begin
					// slots survive; wipers reload from slot 0 as at power-up
					for (int i = 0; i < NUM_CH; i++) begin
						next_st.wiper[i] = st.slot[i][0][WIPER_MSB:0];
						next_st.bufm[i]  = st.slot[i][0][DATA_MSB];
					end
					next_st.asleep   = 1'b1;
					next_st.rd_word  = '0;
					next_st.busy_cnt = '0;
				end
				default: begin
					next_st.busy_cnt = next_st.busy_cnt;
				end
			endcase
		end
		next_st.ready = (next_st.busy_cnt == '0);
	end

	// power-up image is sleep with slot 0 loaded
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign fif.rd_word   = st.rd_word;
	assign ready_out     = st.ready;
	assign asleep_out    = st.asleep;
	assign wiper_out     = st.wiper;
	assign buffer_on_out = st.bufm;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence s_awake_cmd;
		cmd_valid && !st.asleep;
	endsequence

	sequence s_busy_hold;
		!ready_out [*8];
	endsequence

	a_nop_no_change: assert property (s_awake_cmd ##0 cmd_op == OP_NOP |=>
		$stable(st.wiper) && $stable(st.slot) && $stable(st.bufm) && $stable(st.asleep))
		else $error("nop changed state");

	a_sleep_ignores: assert property (cmd_valid && st.asleep && cmd_op != OP_WAKE |=>
		$stable(st.wiper) && $stable(st.slot) && st.asleep)
		else $error("command acted while asleep");

	a_write_loads: assert property (s_awake_cmd ##0 (cmd_op == OP_WRITE && ch_ok) |=>
		st.wiper[$past(ch)] == $past(cmd_data[WIPER_MSB:0]) && $stable(st.bufm))
		else $error("direct write did not load wiper");

	a_step_up_sat: assert property (s_awake_cmd ##0 (cmd_op == OP_STEP_UP && ch_ok) |=>
		st.wiper[$past(ch)] == (($past(st.wiper[ch]) == WIPER_MAX) ?
		WIPER_MAX : $past(st.wiper[ch]) + STEP))
		else $error("step up wrong");

	a_step_dn_sat: assert property (s_awake_cmd ##0 (cmd_op == OP_STEP_DN && ch_ok) |=>
		st.wiper[$past(ch)] == (($past(st.wiper[ch]) == WIPER_MIN) ?
		WIPER_MIN : $past(st.wiper[ch]) - STEP))
		else $error("step down wrong");

	a_wp_blocks: assert property (s_awake_cmd ##0 !wp_ok |=> $stable(st.slot))
		else $error("slot changed under write protect");

	a_buf_recall_only: assert property (!$stable(st.bufm) |->
		$past(cmd_valid && (cmd_op == OP_RECALL || cmd_op == OP_SW_RESET)))
		else $error("buffer bit changed without recall");

	a_busy_hold: assert property (s_awake_cmd ##0 (busy_op && BUSY_CYCLES >= 9) |=>
		s_busy_hold)
		else $error("ready not held low during slot access");

	a_busy_release: assert property (st.busy_cnt == BUSY_ONE && !cmd_valid |=> ready_out)
		else $error("ready not released after access");

	a_reset_sleeps: assert property (s_awake_cmd ##0 cmd_op == OP_SW_RESET |=>
		st.asleep && st.wiper[0] == $past(st.slot[0][0][WIPER_MSB:0]))
		else $error("software reset did not restore power-up state");

	// commands that name a channel the part actually has
	sequence s_chan_cmd;
		s_awake_cmd ##0 ch_ok;
	endsequence

	// slot writers act only on a valid channel with protect released
	sequence s_slot_cmd;
		s_chan_cmd ##0 wp_ok;
	endsequence

	// read-back selection, both sources
	a_read_tap_sel: assert property (s_chan_cmd ##0 cmd_op == OP_READ_TAP |=>
		st.rd_word == {$past(st.bufm[ch]), $past(st.wiper[ch])})
		else $error("read tap selected the wrong word");

	a_read_slot_sel: assert property (s_chan_cmd ##0 cmd_op == OP_READ_SLOT |=>
		st.rd_word == $past(st.slot[ch][cmd_slot]))
		else $error("read slot selected the wrong word");

	// slot contents after each writer
	a_prog_slot: assert property (s_slot_cmd ##0 cmd_op == OP_PROG_SLOT |=>
		st.slot[$past(ch)][$past(cmd_slot)] == $past(cmd_data))
		else $error("program did not write the slot");

	a_store_saves: assert property (s_slot_cmd ##0 cmd_op == OP_STORE |=>
		st.slot[$past(ch)][$past(cmd_slot)] == {$past(st.bufm[ch]), $past(st.wiper[ch])})
		else $error("store did not save the wiper");

	a_erase_word: assert property (s_slot_cmd ##0 cmd_op == OP_ERASE |=>
		st.slot[$past(ch)][$past(cmd_slot)] == SLOT_ERASED)
		else $error("erase did not clear the slot");

	// recall and software reset are the only paths that move the buffer bit together with the wiper
	a_recall_loads: assert property (s_chan_cmd ##0 cmd_op == OP_RECALL |=>
		{st.bufm[$past(ch)], st.wiper[$past(ch)]} == $past(st.slot[ch][cmd_slot]))
		else $error("recall did not load the wiper");

	// sleep and wake act on the whole chip
	a_sleep_enters: assert property (s_awake_cmd ##0 cmd_op == OP_SLEEP |=> st.asleep)
		else $error("sleep command did not take effect");

	a_wake_leaves: assert property (cmd_valid && cmd_op == OP_WAKE |=> !st.asleep)
		else $error("wake command did not leave sleep");

	a_sleep_keeps: assert property (st.asleep && !cmd_valid |=>
		$stable(st.wiper) && $stable(st.bufm) && $stable(st.slot))
		else $error("settings moved while asleep");

	// software reset keeps the slots and frees ready at once
	a_reset_slots: assert property (s_awake_cmd ##0 cmd_op == OP_SW_RESET |=>
		$stable(st.slot) && st.bufm[0] == $past(st.slot[0][0][DATA_MSB]) && ready_out)
		else $error("software reset disturbed the slots");

	a_busy_low: assert property (s_awake_cmd ##0 busy_op |=> !ready_out)
		else $error("ready stayed high on a slot access");
endmodule
`default_nettype wire

// file: inc/dpsc_pkg.sv
// dpsc_pkg: constants, opcodes and frame layout for the dual wiper command decoder
package dpsc_pkg;
	// frame layout, bit positions within the 24-bit frame
	localparam int FRAME_BITS = 24;
	localparam int OP_MSB     = 23;
	localparam int OP_LSB     = 20;
	localparam int SLOT_MSB   = 19;
	localparam int SLOT_LSB   = 18;
	localparam int CH_MSB     = 17;
	localparam int CH_LSB     = 16;
	localparam int DATA_MSB   = 8;
	localparam int WIPER_MSB  = 7;
	localparam int CNT_W      = 5;
	localparam int NUM_SLOTS  = 4;
	localparam int DEF_CH     = 2;

	// stored word: buffer bit on top of eight wiper bits
	typedef logic [DATA_MSB:0] dpsc_word_type;

	localparam logic [7:0]  WIPER_MAX    = 8'hFF;
	localparam logic [7:0]  WIPER_MIN    = 8'h00;
	localparam logic [7:0]  STEP         = 8'h01;
	localparam dpsc_word_type SLOT_ERASED  = 9'h1FF;
	localparam dpsc_word_type SLOT_POWERUP = 9'h080;
	localparam logic [14:0] RD_PAD       = 15'h0000;

	// non-volatile access time, longest figure, rounded down to cycles
	localparam int CLK_SYS_KHZ  = 10000;
	localparam int SAVE_TIME_MS = 2;
	localparam int SAVE_CYCLES  = SAVE_TIME_MS * CLK_SYS_KHZ;
	localparam int BUSY_W       = 16;

	typedef enum logic [3:0] {
		OP_NOP       = 4'h0,
		OP_WAKE      = 4'h1,
		OP_PROG_SLOT = 4'h2,
		OP_STORE     = 4'h3,
		OP_WRITE     = 4'h4,
		OP_STEP_UP   = 4'h7,
		OP_SLEEP     = 4'h8,
		OP_SW_RESET  = 4'h9,
		OP_READ_SLOT = 4'hA,
		OP_RECALL    = 4'hB,
		OP_READ_TAP  = 4'hC,
		OP_ERASE     = 4'hD,
		OP_STEP_DN   = 4'hF
	} dpsc_op_type;
endpackage

// file: inc/dpsc_frame_if.sv
// dpsc_frame_if: frame word and read-back word passed between link and core
`timescale 1ns/1ps
`default_nettype none
interface dpsc_frame_if;
	import dpsc_pkg::*;
	logic [FRAME_BITS-1:0] frame;     // last complete frame, link domain
	logic                  frame_tog; // flips once per complete frame
	dpsc_word_type         rd_word;   // read-back word, core domain, quasi-static
	modport link (output frame, output frame_tog, input rd_word);
	modport core (input frame, input frame_tog, output rd_word);
endinterface
`default_nettype wire

// file: src/dpsc_sync.sv
// dpsc_sync: two flip-flop synchroniser for slow levels and toggles
`timescale 1ns/1ps
`default_nettype none
module dpsc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dpsc_sync_type;

	dpsc_sync_type st;
	dpsc_sync_type next_st;

	initial begin
		if (W < 1) $error("dpsc_sync width must be at least one");
	end

	// s1 feeds s2 only; nothing else looks at it
	always_comb begin
		next_st.s1 = d_in;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q_out = st.s2;
endmodule
`default_nettype wire

// file: src/dpsc_link.sv
// dpsc_link: serial shifter on the link clock, frame capture and read-back output
`timescale 1ns/1ps
`default_nettype none
module dpsc_link
	import dpsc_pkg::*;
(
	input  wire logic   spi_clk_in,
	input  wire logic   rst_in,
	input  wire logic   spi_cs_n_in,
	input  wire logic   spi_sdi_in,
	output logic        spi_sdo_out,
	dpsc_frame_if.link  fif
);
	typedef struct packed {
		logic [FRAME_BITS-1:0] shreg;
		logic [FRAME_BITS-1:0] frame;
		logic                  tog;
	} dpsc_link_type;

	localparam logic [CNT_W-1:0] LAST_EDGE = CNT_W'(FRAME_BITS - 1);
	localparam logic [CNT_W-1:0] FULL      = CNT_W'(FRAME_BITS);
	localparam logic [CNT_W-1:0] ONE       = 5'h01;

	dpsc_link_type        st;
	dpsc_link_type        next_st;
	logic [CNT_W-1:0]     cnt;
	logic                 cnt_clr;
	logic [FRAME_BITS-1:0] rd_frame;

	// link clock is still outside frames, so chip select itself clears the position
	assign cnt_clr = rst_in | spi_cs_n_in;

	// bit position in the frame, stops at 24 so extra pulses never fire twice
	always_ff @(posedge spi_clk_in or posedge cnt_clr) begin
		if (cnt_clr) begin
			cnt <= '0;
		end else if (cnt != FULL) begin
			cnt <= cnt + ONE;
		end
	end

	// msb first shifting on rising edges; 24th edge publishes the frame
	always_comb begin
		next_st = st;
		next_st.shreg = {st.shreg[FRAME_BITS-2:0], spi_sdi_in};
		if (cnt == LAST_EDGE) begin
			next_st.frame = {st.shreg[FRAME_BITS-2:0], spi_sdi_in};
			next_st.tog   = ~st.tog;
		end
	end

	always_ff @(posedge spi_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// read word is held steady by the core between frames, so it is read directly
	assign rd_frame = {RD_PAD, fif.rd_word};

	// output moves on falling edges; bit 23 is a zero pad already valid at select
	always_ff @(negedge spi_clk_in or posedge rst_in) begin
		if (rst_in) begin
			spi_sdo_out <= 1'b0;
		end else if (cnt != '0 && cnt < FULL) begin
			spi_sdo_out <= rd_frame[LAST_EDGE - cnt];
		end else begin
			spi_sdo_out <= 1'b0;
		end
	end

	assign fif.frame     = st.frame;
	assign fif.frame_tog = st.tog;
endmodule
`default_nettype wire

// file: verification/dpsc_spi_host.sv
// dpsc_spi_host: host-side serial model that clocks whole 24-bit frames
`timescale 1ns/1ps
`default_nettype none
module dpsc_spi_host (
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      sdi_out,
	input  wire logic sdo_in
);
	// link idles with clock low and chip deselected
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
	end

	// msb first, 24 pulses, clock still outside frames
	task automatic xfer(input logic [23:0] f, output logic [23:0] r);
		cs_n_out = 1'b0;
		#16;
		r[23] = sdo_in;
		for (int i = 23; i >= 0; i--) begin
			sdi_out = f[i];
			#16 sclk_out = 1'b1;
			#16 sclk_out = 1'b0;
			#2;
			if (i > 0) r[i-1] = sdo_in;
		end
		#16 cs_n_out = 1'b1;
		sdi_out = ~sdi_out; // released data line must not hold the last bit
	endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// tb: self-checking bench for the dual wiper command decoder
`timescale 1ns/1ps
`default_nettype none
module tb
	import dpsc_pkg::*;
;
	localparam int BUSY = 16;
	logic            clk_sys_in;
	logic            rst_in;
	logic            wp_n_in;
	logic            sclk;
	logic            cs_n;
	logic            sdi;
	logic            sdo;
	logic            ready;
	logic            asleep;
	logic [1:0][7:0] wiper;
	logic [1:0]      buf_on;
	int              num_errors;
	int              n_checks;
	logic [31:0]     lfsr;
	logic [7:0]      m_wip [2];
	logic            m_buf [2];
	dpsc_word_type   m_slot [2][4];
	dpsc_word_type   m_rd;
	logic            m_sleep;
	logic            m_wp;
	logic            rd_pend;

	dpsc_core #(.NUM_CH(2), .BUSY_CYCLES(BUSY)) dpsc_core_i (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .spi_clk_in(sclk),
		.spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .wp_n_in(wp_n_in),
		.spi_sdo_out(sdo), .ready_out(ready), .asleep_out(asleep),
		.wiper_out(wiper), .buffer_on_out(buf_on)
	);
	dpsc_spi_host dpsc_spi_host_i (
		.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo)
	);

	// 10 MHz system clock
	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk_out(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_rd(input logic [23:0] e, input logic [23:0] g);
		chk_out("readback", e, g);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// power-up image: wipers and buffer bits from slot 0, asleep
	task automatic reset_model;
		for (int c = 0; c < 2; c++) begin
			m_wip[c] = m_slot[c][0][7:0];
			m_buf[c] = m_slot[c][0][8];
		end
		m_sleep = 1'b1;
		m_rd = '0;
	endtask

	task automatic chk_all(input logic busy);
		for (int c = 0; c < 2; c++) begin
			chk_out("wiper", m_wip[c], wiper[c]);
			chk_out("buffer", m_buf[c], buf_on[c]);
		end
		chk_out("asleep", m_sleep, asleep);
		chk_out("ready", !busy, ready);
	endtask

	task automatic set_wp(input logic v);
		@(posedge clk_sys_in) wp_n_in <= v;
		m_wp = v;
		repeat (4) @(posedge clk_sys_in);
	endtask

	task automatic cmd(input logic [3:0] op, input logic [1:0] sl, input logic [1:0] ch,
			input dpsc_word_type d);
		logic [23:0] r;
		logic        busy;
		logic        ok;
		int          k;
		dpsc_spi_host_i.xfer({op, sl, ch, 7'h00, d}, r);
		if (rd_pend) chk_rd({15'h0000, m_rd}, r);
		rd_pend = 1'b0;
		ok = (ch < 2'h2);
		busy = !m_sleep && (op inside {4'hC, 4'hA, 4'h2, 4'hB, 4'h3, 4'hD});
		if (m_sleep) begin
			if (op == OP_WAKE) m_sleep = 1'b0;
		end else begin
			case (op)
				OP_WRITE: if (ok) m_wip[ch] = d[7:0];
				OP_STEP_UP: if (ok && m_wip[ch] != 8'hFF) m_wip[ch]++;
				OP_STEP_DN: if (ok && m_wip[ch] != 8'h00) m_wip[ch]--;
				OP_PROG_SLOT: if (ok && m_wp) m_slot[ch][sl] = d;
				OP_STORE: if (ok && m_wp) m_slot[ch][sl] = {m_buf[ch], m_wip[ch]};
				OP_ERASE: if (ok && m_wp) m_slot[ch][sl] = 9'h1FF;
				OP_RECALL: if (ok) {m_buf[ch], m_wip[ch]} = m_slot[ch][sl];
				OP_READ_TAP: if (ok) begin
					m_rd = {m_buf[ch], m_wip[ch]};
					rd_pend = 1'b1;
				end
				OP_READ_SLOT: if (ok) begin
					m_rd = m_slot[ch][sl];
					rd_pend = 1'b1;
				end
				OP_SLEEP: m_sleep = 1'b1;
				OP_SW_RESET: reset_model();
				default: ;
			endcase
		end
		repeat (6) @(negedge clk_sys_in);
		chk_all(busy);
		// host waits for ready before the next frame
		k = 0;
		while (ready !== 1'b1 && k < 100) begin
			@(negedge clk_sys_in);
			k++;
		end
		if (ready !== 1'b1) begin
			num_errors++;
			$display("MISMATCH ready expected 1 seen %b", ready);
			complete_run();
		end
	endtask

	// directed groups, then seeded random frames
	initial begin
		rst_in = 1'b1;
		wp_n_in = 1'b1;
		num_errors = 0;
		n_checks = 0;
		lfsr = 32'hA65C;
		m_wp = 1'b1;
		rd_pend = 1'b0;
		foreach (m_slot[c, s]) m_slot[c][s] = 9'h080;
		reset_model();
		repeat (8) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(negedge clk_sys_in);
		chk_all(1'b0);
		$display("test reset done");
		cmd(OP_WRITE, 2'h0, 2'h0, 9'h055);
		cmd(OP_WAKE, 2'h0, 2'h0, 9'h000);
		cmd(OP_WRITE, 2'h0, 2'h0, 9'h1FE);
		repeat (2) cmd(OP_STEP_UP, 2'h0, 2'h0, 9'h000);
		cmd(OP_WRITE, 2'h0, 2'h1, 9'h001);
		repeat (2) cmd(OP_STEP_DN, 2'h0, 2'h1, 9'h000);
		$display("test steps done");
		cmd(OP_ERASE, 2'h1, 2'h0, 9'h000);
		cmd(OP_PROG_SLOT, 2'h1, 2'h0, 9'h1A5);
		cmd(OP_READ_SLOT, 2'h1, 2'h0, 9'h000);
		cmd(OP_RECALL, 2'h1, 2'h0, 9'h000);
		cmd(OP_READ_TAP, 2'h0, 2'h0, 9'h000);
		cmd(OP_STORE, 2'h3, 2'h1, 9'h000);
		cmd(OP_READ_SLOT, 2'h3, 2'h1, 9'h000);
		cmd(OP_NOP, 2'h0, 2'h0, 9'h1FF);
		$display("test slots done");
		set_wp(1'b0);
		cmd(OP_ERASE, 2'h1, 2'h0, 9'h000);
		cmd(OP_PROG_SLOT, 2'h3, 2'h1, 9'h033);
		cmd(OP_READ_SLOT, 2'h3, 2'h1, 9'h000);
		cmd(OP_RECALL, 2'h1, 2'h0, 9'h000);
		set_wp(1'b1);
		$display("test protect done");
		cmd(OP_SLEEP, 2'h0, 2'h0, 9'h000);
		cmd(OP_STEP_UP, 2'h0, 2'h1, 9'h000);
		cmd(OP_WAKE, 2'h0, 2'h0, 9'h000);
		cmd(OP_SW_RESET, 2'h0, 2'h0, 9'h000);
		cmd(OP_WAKE, 2'h0, 2'h0, 9'h000);
		$display("test power done");
		repeat (80) begin
			lfsr = next_rand(lfsr);
			if (lfsr[7:4] == 4'h0) set_wp(lfsr[8]);
			cmd(lfsr[31:28], lfsr[27:26], lfsr[25:24], lfsr[16:8]);
		end
		cmd(OP_NOP, 2'h0, 2'h0, 9'h000);
		$display("test random done");
		complete_run();
	end
endmodule
`default_nettype wire
